// ### shared/dsp_cfg.svh
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// Register byte offsets
`define DSP_ADDR_CTRL 8'h00
`define DSP_ADDR_COUNT 8'h04
`define DSP_ADDR_CMP_A 8'h08
`define DSP_ADDR_CMP_B 8'h0c
`define DSP_ADDR_CAPTURE 8'h10
`define DSP_ADDR_FLAGS 8'h14
`define DSP_ADDR_PIN_DIR 8'h18
`define DSP_ADDR_STATUS 8'h1c

// Control register fields
`define DSP_CTRL_WGM_MSB 3
`define DSP_CTRL_WGM_LSB 0
`define DSP_CTRL_CLK_MSB 6
`define DSP_CTRL_CLK_LSB 4
`define DSP_CTRL_COMA_MSB 9
`define DSP_CTRL_COMA_LSB 8
`define DSP_CTRL_COMB_MSB 11
`define DSP_CTRL_COMB_LSB 10
`define DSP_CTRL_WIDTH 12

// Flag register bits
`define DSP_FLAG_OVF 0
`define DSP_FLAG_MATCH_A 1
`define DSP_FLAG_MATCH_B 2
`define DSP_FLAG_CAPTURE 3
`define DSP_FLAG_WIDTH 4

// Reset values
`define DSP_CTRL_RESET 12'h000
`define DSP_COUNT_RESET 16'h0000
`define DSP_CMP_RESET 16'h0000
`define DSP_CAPTURE_RESET 16'h0000
`define DSP_FLAGS_RESET 4'h0
`define DSP_PIN_DIR_RESET 2'h0

// Fixed TOP values
`define DSP_TOP_8BIT 16'h00ff
`define DSP_TOP_9BIT 16'h01ff
`define DSP_TOP_10BIT 16'h03ff
`define DSP_TOP_MAX 16'hffff
`define DSP_BOTTOM 16'h0000

// Prescaler terminal counts, divider minus one
`define DSP_DIV1_TERM 10'h000
`define DSP_DIV8_TERM 10'h007
`define DSP_DIV64_TERM 10'h03f
`define DSP_DIV256_TERM 10'h0ff
`define DSP_DIV1024_TERM 10'h3ff

`endif

// ### shared/dsp_pkg.sv
package dsp_pkg;

  typedef enum logic [3:0] {
    DSP_WGM_PC8 = 4'h1,
    DSP_WGM_PC9 = 4'h2,
    DSP_WGM_PC10 = 4'h3,
    DSP_WGM_PFC_CAP = 4'h8,
    DSP_WGM_PFC_CMPA = 4'h9,
    DSP_WGM_PC_CAP = 4'ha,
    DSP_WGM_PC_CMPA = 4'hb
  } dsp_wgm_t;

  typedef enum logic [0:0] {
    DSP_UP = 1'b0,
    DSP_DOWN = 1'b1
  } dsp_dir_t;

  typedef enum logic [1:0] {
    DSP_COM_OFF = 2'h0,
    DSP_COM_TOGGLE = 2'h1,
    DSP_COM_NONINV = 2'h2,
    DSP_COM_INV = 2'h3
  } dsp_com_t;

  typedef enum logic [2:0] {
    DSP_CLK_STOP = 3'h0,
    DSP_CLK_DIV1 = 3'h1,
    DSP_CLK_DIV8 = 3'h2,
    DSP_CLK_DIV64 = 3'h3,
    DSP_CLK_DIV256 = 3'h4,
    DSP_CLK_DIV1024 = 3'h5
  } dsp_clk_sel_t;

endpackage : dsp_pkg

// ### shared/dsp_tick_if.sv
`timescale 1ns/1ps

interface dsp_tick_if;
  logic [2:0] clk_sel;
  logic tick;

  modport prescaler (
    input clk_sel,
    output tick
  );

  modport timer (
    output clk_sel,
    input tick
  );
endinterface : dsp_tick_if

// ### hdl/dsp_prescaler.sv
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module dsp_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Tick carrier
  dsp_tick_if.prescaler tk
);

  logic [9:0] div_reg;
  logic tick_reg;

  function automatic logic [9:0] term_of(input logic [2:0] sel);
    case (sel)
      dsp_pkg::DSP_CLK_DIV1: term_of = `DSP_DIV1_TERM;
      dsp_pkg::DSP_CLK_DIV8: term_of = `DSP_DIV8_TERM;
      dsp_pkg::DSP_CLK_DIV64: term_of = `DSP_DIV64_TERM;
      dsp_pkg::DSP_CLK_DIV256: term_of = `DSP_DIV256_TERM;
      dsp_pkg::DSP_CLK_DIV1024: term_of = `DSP_DIV1024_TERM;
      default: term_of = `DSP_DIV1_TERM;
    endcase
  endfunction : term_of

  wire run = (tk.clk_sel != dsp_pkg::DSP_CLK_STOP) && (tk.clk_sel <= dsp_pkg::DSP_CLK_DIV1024);
  wire at_term = (div_reg >= term_of(tk.clk_sel));
  wire [9:0] div_next = (!run || at_term) ? 10'h000 : div_reg + 10'h001;

  // tick is an enable, not a clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 10'h000;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= run && at_term;
    end
  end

  assign tk.tick = tick_reg;

endmodule : dsp_prescaler

// ### hdl/dsp_pwm_timer.sv
// Overview of operation
// - Count zero up to TOP, then down
// - Reverse at TOP on the next tick, no hold
// - Counter equals compare sets match flag
// - Phase correct: overflow flag at zero
// - Phase correct: TOP-source flag at TOP load
// - Phase correct: load compares at TOP
// - Fixed TOP masks upper compare bits
// - Mode two non-inverted, three inverted
// - Clear on up match, set on down
// - Pin driven only when direction output
// - Zero compare low, TOP compare high
// - Channel A toggle with A-as-TOP or capture-as-TOP
// - Frequency correct TOP: capture or A
// - Frequency correct: load and overflow at zero
// - Frequency correct: TOP-source flag at TOP
// - Prescaler divides by 1..1024
// - Fully synchronous, tick as enable
// - Phase correct TOP source per mode
// - Capture unbuffered, compares buffered
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module dsp_pwm_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Waveform pins
  output logic wave_out_a,
  output logic wave_oe_a,
  output logic wave_out_b,
  output logic wave_oe_b
);

  dsp_tick_if tk ();

  logic [`DSP_CTRL_WIDTH-1:0] ctrl_reg;
  logic [15:0] count_reg;
  dsp_pkg::dsp_dir_t dir_reg;
  dsp_pkg::dsp_dir_t dir_next;
  logic [15:0] cmp_a_buf_reg;
  logic [15:0] cmp_b_buf_reg;
  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic [15:0] capture_reg;
  logic [`DSP_FLAG_WIDTH-1:0] flags_reg;
  logic [1:0] pin_dir_reg;
  logic wave_a_reg;
  logic wave_b_reg;
  logic oe_a_reg;
  logic oe_b_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  dsp_prescaler dsp_prescaler_i (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk.prescaler)
  );

  function automatic logic is_dual(input logic [3:0] m);
    case (m)
      dsp_pkg::DSP_WGM_PC8, dsp_pkg::DSP_WGM_PC9, dsp_pkg::DSP_WGM_PC10,
      dsp_pkg::DSP_WGM_PFC_CAP, dsp_pkg::DSP_WGM_PFC_CMPA,
      dsp_pkg::DSP_WGM_PC_CAP, dsp_pkg::DSP_WGM_PC_CMPA: is_dual = 1'b1;
      default: is_dual = 1'b0;
    endcase
  endfunction : is_dual

  function automatic logic [15:0] fixed_mask(input logic [3:0] m);
    case (m)
      dsp_pkg::DSP_WGM_PC8: fixed_mask = `DSP_TOP_8BIT;
      dsp_pkg::DSP_WGM_PC9: fixed_mask = `DSP_TOP_9BIT;
      dsp_pkg::DSP_WGM_PC10: fixed_mask = `DSP_TOP_10BIT;
      default: fixed_mask = `DSP_TOP_MAX;
    endcase
  endfunction : fixed_mask

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmpa, input logic [15:0] cap);
    case (m)
      dsp_pkg::DSP_WGM_PC8, dsp_pkg::DSP_WGM_PC9, dsp_pkg::DSP_WGM_PC10: top_of = fixed_mask(m);
      dsp_pkg::DSP_WGM_PFC_CAP, dsp_pkg::DSP_WGM_PC_CAP: top_of = cap;
      dsp_pkg::DSP_WGM_PFC_CMPA, dsp_pkg::DSP_WGM_PC_CMPA: top_of = cmpa;
      default: top_of = `DSP_TOP_MAX;
    endcase
  endfunction : top_of

  // next pin level on a match
  function automatic logic wave_step(input logic [1:0] com, input logic tog_ok, input logic hit, input logic up,
                                     input logic cur);
    if (!hit) begin
      wave_step = cur;
    end else begin
      case (com)
        dsp_pkg::DSP_COM_NONINV: wave_step = ~up;
        dsp_pkg::DSP_COM_INV: wave_step = up;
        dsp_pkg::DSP_COM_TOGGLE: wave_step = tog_ok ? ~cur : cur;
        default: wave_step = cur;
      endcase
    end
  endfunction : wave_step

  // Control fields
  wire [3:0] mode = ctrl_reg[`DSP_CTRL_WGM_MSB:`DSP_CTRL_WGM_LSB];
  wire [1:0] com_a = ctrl_reg[`DSP_CTRL_COMA_MSB:`DSP_CTRL_COMA_LSB];
  wire [1:0] com_b = ctrl_reg[`DSP_CTRL_COMB_MSB:`DSP_CTRL_COMB_LSB];
  wire dual = is_dual(mode);
  wire pfc = (mode == dsp_pkg::DSP_WGM_PFC_CAP) || (mode == dsp_pkg::DSP_WGM_PFC_CMPA);
  wire top_is_a = (mode == dsp_pkg::DSP_WGM_PFC_CMPA) || (mode == dsp_pkg::DSP_WGM_PC_CMPA);
  wire top_is_cap = (mode == dsp_pkg::DSP_WGM_PFC_CAP) || (mode == dsp_pkg::DSP_WGM_PC_CAP);
  wire tog_ok = top_is_a || top_is_cap;
  assign tk.clk_sel = ctrl_reg[`DSP_CTRL_CLK_MSB:`DSP_CTRL_CLK_LSB];

  // APB decode
  wire access = psel && penable && pready_reg;
  wire wr_en = access && pwrite;
  wire hit_ctrl = (paddr == `DSP_ADDR_CTRL);
  wire hit_count = (paddr == `DSP_ADDR_COUNT);
  wire hit_cmp_a = (paddr == `DSP_ADDR_CMP_A);
  wire hit_cmp_b = (paddr == `DSP_ADDR_CMP_B);
  wire hit_cap = (paddr == `DSP_ADDR_CAPTURE);
  wire hit_flags = (paddr == `DSP_ADDR_FLAGS);
  wire hit_dir = (paddr == `DSP_ADDR_PIN_DIR);
  wire hit_stat = (paddr == `DSP_ADDR_STATUS);
  wire mapped = hit_ctrl || hit_count || hit_cmp_a || hit_cmp_b || hit_cap || hit_flags || hit_dir || hit_stat;
  wire wr_ctrl = wr_en && hit_ctrl;
  wire wr_count = wr_en && hit_count;
  wire wr_cmp_a = wr_en && hit_cmp_a;
  wire wr_cmp_b = wr_en && hit_cmp_b;
  wire wr_cap = wr_en && hit_cap;
  wire wr_flags = wr_en && hit_flags;
  wire wr_dir = wr_en && hit_dir;
  wire [31:0] rd_data =
    hit_ctrl ? {20'h00000, ctrl_reg} :
    hit_count ? {16'h0000, count_reg} :
    hit_cmp_a ? {16'h0000, cmp_a_buf_reg} :
    hit_cmp_b ? {16'h0000, cmp_b_buf_reg} :
    hit_cap ? {16'h0000, capture_reg} :
    hit_flags ? {28'h0000000, flags_reg} :
    hit_dir ? {30'h00000000, pin_dir_reg} :
    hit_stat ? {31'h00000000, dir_reg} :
    32'h00000000;

  // Counter events
  // tick qualifies every counter step; APB writes load it without a tick
  wire tick_en = tk.tick && dual;
  wire [15:0] top = top_of(mode, cmp_a_reg, capture_reg);
  wire at_top = (count_reg == top);
  wire at_bot = (count_reg == `DSP_BOTTOM);
  wire dir_up = (dir_reg == dsp_pkg::DSP_UP);
  wire top_evt = tick_en && dir_up && at_top;
  wire bot_evt = tick_en && !dir_up && at_bot;
  // match only where counter reaches value
  wire match_a = tick_en && (count_reg == cmp_a_reg);
  wire match_b = tick_en && (count_reg == cmp_b_reg);
  // TOP counts as falling, BOTTOM as rising
  wire up_eff = (dir_up && !at_top) || at_bot;
  wire load_cmp = dual ? (pfc ? bot_evt : top_evt) : 1'b1;

  wire step_down = (dir_up && at_top) || (!dir_up && !at_bot);
  wire [15:0] count_step = step_down ? count_reg - 16'h0001 : count_reg + 16'h0001;
  wire [15:0] count_next = wr_count ? pwdata[15:0] : (tick_en ? count_step : count_reg);

  always_comb begin
    dir_next = dir_reg;
    case (dir_reg)
      dsp_pkg::DSP_UP: begin
        if (tick_en && at_top) begin
          dir_next = dsp_pkg::DSP_DOWN;
        end
      end
      dsp_pkg::DSP_DOWN: begin
        if (tick_en && at_bot) begin
          dir_next = dsp_pkg::DSP_UP;
        end
      end
      default: dir_next = dsp_pkg::DSP_UP;
    endcase
  end

  wire [15:0] cmp_wdata = pwdata[15:0] & fixed_mask(mode);
  wire [15:0] cmp_a_buf_next = wr_cmp_a ? cmp_wdata : cmp_a_buf_reg;
  wire [15:0] cmp_b_buf_next = wr_cmp_b ? cmp_wdata : cmp_b_buf_reg;
  wire [15:0] cmp_a_next = load_cmp ? cmp_a_buf_reg : cmp_a_reg;
  wire [15:0] cmp_b_next = load_cmp ? cmp_b_buf_reg : cmp_b_reg;
  wire [15:0] capture_next = wr_cap ? pwdata[15:0] : capture_reg;

  // Flag sets; set beats a same-cycle clear
  // overflow at bottom
  wire set_ovf = bot_evt;
  wire set_a = match_a || (top_evt && top_is_a);
  wire set_b = match_b;
  wire set_cap = top_evt && top_is_cap;
  wire [3:0] flag_set = {set_cap, set_b, set_a, set_ovf};
  wire [3:0] flag_clr = wr_flags ? pwdata[3:0] : 4'h0;
  wire [3:0] flags_next = (flags_reg & ~flag_clr) | flag_set;

  // Waveform levels; B has no toggle
  wire wave_a_next = wave_step(com_a, tog_ok, match_a, up_eff, wave_a_reg);
  wire wave_b_next = wave_step(com_b, 1'b0, match_b, up_eff, wave_b_reg);
  // drive pin only with direction set
  wire oe_a_next = pin_dir_reg[0] && (com_a != dsp_pkg::DSP_COM_OFF) &&
                   ((com_a != dsp_pkg::DSP_COM_TOGGLE) || tog_ok);
  wire oe_b_next = pin_dir_reg[1] && (com_b != dsp_pkg::DSP_COM_OFF) && (com_b != dsp_pkg::DSP_COM_TOGGLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `DSP_CTRL_RESET;
      count_reg <= `DSP_COUNT_RESET;
      dir_reg <= dsp_pkg::DSP_UP;
      cmp_a_buf_reg <= `DSP_CMP_RESET;
      cmp_b_buf_reg <= `DSP_CMP_RESET;
      cmp_a_reg <= `DSP_CMP_RESET;
      cmp_b_reg <= `DSP_CMP_RESET;
      capture_reg <= `DSP_CAPTURE_RESET;
      flags_reg <= `DSP_FLAGS_RESET;
      pin_dir_reg <= `DSP_PIN_DIR_RESET;
    end else begin
      ctrl_reg <= wr_ctrl ? pwdata[`DSP_CTRL_WIDTH-1:0] : ctrl_reg;
      count_reg <= count_next;
      dir_reg <= dir_next;
      cmp_a_buf_reg <= cmp_a_buf_next;
      cmp_b_buf_reg <= cmp_b_buf_next;
      cmp_a_reg <= cmp_a_next;
      cmp_b_reg <= cmp_b_next;
      capture_reg <= capture_next;
      flags_reg <= flags_next;
      pin_dir_reg <= wr_dir ? pwdata[1:0] : pin_dir_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_a_reg <= 1'b0;
      wave_b_reg <= 1'b0;
      oe_a_reg <= 1'b0;
      oe_b_reg <= 1'b0;
    end else begin
      wave_a_reg <= wave_a_next;
      wave_b_reg <= wave_b_next;
      oe_a_reg <= oe_a_next;
      oe_b_reg <= oe_b_next;
    end
  end

  // Read data captured in setup so access is wait-free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= (psel && !penable && !pwrite) ? rd_data : prdata_reg;
      pready_reg <= psel && !penable;
      pslverr_reg <= psel && !penable && !mapped;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign wave_out_a = wave_a_reg;
  assign wave_oe_a = oe_a_reg;
  assign wave_out_b = wave_b_reg;
  assign wave_oe_b = oe_b_reg;

  a_up_slope: assert property (@(posedge pclk) disable iff (!presetn)
    (tick_en && dir_up && !at_top && !wr_count) |=> (count_reg == $past(count_reg) + 16'h0001))
    else $error("counter did not increment on up slope");

  a_top_turn: assert property (@(posedge pclk) disable iff (!presetn)
    (top_evt && !wr_count) |=> (dir_reg == dsp_pkg::DSP_DOWN) && (count_reg == $past(count_reg) - 16'h0001))
    else $error("counter did not reverse after TOP");

  a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
    match_b |=> flags_reg[`DSP_FLAG_MATCH_B])
    else $error("match flag B not set");

  a_bottom_ovf: assert property (@(posedge pclk) disable iff (!presetn)
    (tick_en && !dir_up && at_bot) |=> flags_reg[`DSP_FLAG_OVF] && (dir_reg == dsp_pkg::DSP_UP))
    else $error("overflow flag not set at bottom");

  a_top_capflag: assert property (@(posedge pclk) disable iff (!presetn)
    (tick_en && dir_up && at_top && top_is_cap) |=> flags_reg[`DSP_FLAG_CAPTURE])
    else $error("capture flag not set at TOP");

  a_pc_load: assert property (@(posedge pclk) disable iff (!presetn)
    (dual && !pfc && !top_evt && $past(dual)) |=> $stable(cmp_b_reg) || $past(top_evt, 2))
    else $error("compare loaded away from TOP");

  a_pfc_load: assert property (@(posedge pclk) disable iff (!presetn)
    (pfc && bot_evt) |=> (cmp_a_reg == $past(cmp_a_buf_reg)) && (cmp_b_reg == $past(cmp_b_buf_reg)))
    else $error("compare not loaded at bottom");

  a_cmp_mask: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmp_a |=> ((cmp_a_buf_reg & ~fixed_mask($past(mode))) == 16'h0000))
    else $error("compare upper bits not masked");

  a_noninv_up: assert property (@(posedge pclk) disable iff (!presetn)
    (match_a && up_eff && com_a == dsp_pkg::DSP_COM_NONINV) |=> !wave_a_reg)
    else $error("non-inverted output not cleared on up match");

  a_oe_gate: assert property (@(posedge pclk) disable iff (!presetn)
    wave_oe_b |-> $past(pin_dir_reg[1]))
    else $error("pin driven without direction bit");

  a_a_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (match_a && top_is_a && com_a == dsp_pkg::DSP_COM_TOGGLE) |=> (wave_a_reg != $past(wave_a_reg)))
    else $error("channel A did not toggle");

endmodule : dsp_pwm_timer

// ### testbench/dsp_pwm_timer_test.sv
`timescale 1ns/1ps
`include "dsp_cfg.svh"

module dsp_pwm_timer_test;
  // Bus and pins
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wave_out_a;
  logic wave_oe_a;
  logic wave_out_b;
  logic wave_oe_b;
  // Bench state
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  int ha;
  int hb;
  logic [15:0] cnt [0:8];
  logic down;
  int divs [0:4] = '{1, 8, 64, 256, 1024};
  logic [15:0] fixed_top [1:3] = '{`DSP_TOP_8BIT, `DSP_TOP_9BIT, `DSP_TOP_10BIT};

  dsp_pwm_timer dsp_pwm_timer_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wave_out_a(wave_out_a),
    .wave_oe_a(wave_oe_a),
    .wave_out_b(wave_out_b),
    .wave_oe_b(wave_oe_b)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Hang guard, well above the longest run
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
    check(err, 1'b0);
  endtask : rdchk

  // High cycles of both waves over n clocks
  task automatic measure(input int n);
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(posedge pclk);
      ha += (wave_out_a === 1'b1);
      hb += (wave_out_b === 1'b1);
    end
  endtask : measure

  function automatic logic [31:0] ctrl(input logic [3:0] m, input logic [2:0] c, input logic [1:0] a,
                                       input logic [1:0] b);
    return {20'h0, b, a, 1'b0, c, m};
  endfunction : ctrl

  initial begin
    int ca [0:2] = '{0, 0, 1};
    int cb [0:2] = '{3, 3, 2};
    logic [1:0] wa [0:2] = '{2'h2, 2'h3, 2'h2};
    logic [1:0] wb [0:2] = '{2'h2, 2'h3, 2'h3};
    int ea [0:2] = '{0, 60, 20};
    int eb [0:2] = '{60, 0, 20};
    logic [3:0] fm [0:2] = '{4'h9, 4'hb, 4'h8};
    logic [1:0] fa [0:2] = '{2'h1, 2'h1, 2'h2};
    logic [1:0] fb [0:2] = '{2'h0, 2'h1, 2'h2};
    int fea [0:2] = '{30, 30, 60};
    logic [3:0] ff [0:2] = '{4'h7, 4'h7, 4'hf};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check({wave_out_a, wave_oe_a, wave_out_b, wave_oe_b}, 4'h0);
    rdchk(`DSP_ADDR_COUNT, 32'h0);
    rdchk(`DSP_ADDR_FLAGS, 32'h0);
    rdchk(`DSP_ADDR_STATUS, 32'h0);
    xfer(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("Test reset and map done");

    // Fixed resolutions, clock stopped
    for (int m = 1; m <= 3; m++) begin
      wr(`DSP_ADDR_CTRL, ctrl(m[3:0], 3'h0, 2'h0, 2'h0));
      wr(`DSP_ADDR_CMP_A, 32'hf5a5);
      wr(`DSP_ADDR_CMP_B, 32'hffff);
      rdchk(`DSP_ADDR_CMP_A, {16'h0, 16'hf5a5 & fixed_top[m]});
      rdchk(`DSP_ADDR_CMP_B, {16'h0, fixed_top[m]});
    end
    wr(`DSP_ADDR_CTRL, 32'h0);
    wr(`DSP_ADDR_CAPTURE, 32'h3);
    wr(`DSP_ADDR_PIN_DIR, 32'h3);
    check({wave_oe_a, wave_oe_b}, 2'h0);
    $display("Test masking done");

    // Capture as TOP = 3, polarity and extremes
    for (int k = 0; k < 3; k++) begin
      wr(`DSP_ADDR_CMP_A, ca[k]);
      wr(`DSP_ADDR_CMP_B, cb[k]);
      wr(`DSP_ADDR_CTRL, ctrl(4'ha, 3'h1, wa[k], wb[k]));
      repeat (30) @(posedge pclk);
      measure(60);
      check(ha, ea[k]);
      check(hb, eb[k]);
      check({wave_oe_a, wave_oe_b}, 2'h3);
    end
    $display("Test polarity done");

    // Count order at divide by 1024, reads one tick apart
    wr(`DSP_ADDR_CTRL, ctrl(4'ha, 3'h5, 2'h2, 2'h3));
    repeat (1500) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      xfer(1'b0, `DSP_ADDR_COUNT, 32'h0);
      cnt[i] = rd[15:0];
      repeat (1021) @(posedge pclk);
    end
    down = cnt[1] < cnt[0];
    for (int i = 1; i < 8; i++) begin
      if (!down && cnt[i] == 16'h3) begin
        down = 1'b1;
      end else if (down && cnt[i] == 16'h0) begin
        down = 1'b0;
      end
      check(cnt[i + 1], down ? cnt[i] - 16'h1 : cnt[i] + 16'h1);
    end
    $display("Test count order done");

    // Period is 2 * N * TOP clocks for each divider
    for (int k = 0; k < 5; k++) begin
      wr(`DSP_ADDR_CTRL, ctrl(4'ha, 3'(k + 1), 2'h2, 2'h3));
      repeat (6 * divs[k] + 10) @(posedge pclk);
      measure(6 * divs[k]);
      check(ha, 2 * divs[k]);
      check(hb, 2 * divs[k]);
    end
    $display("Test divider done");

    // Flags in phase correct with capture TOP, then compare above TOP
    wr(`DSP_ADDR_CTRL, ctrl(4'ha, 3'h1, 2'h2, 2'h3));
    repeat (20) @(posedge pclk);
    wr(`DSP_ADDR_CTRL, ctrl(4'ha, 3'h0, 2'h2, 2'h3));
    rdchk(`DSP_ADDR_FLAGS, 32'hf);
    wr(`DSP_ADDR_FLAGS, 32'hf);
    rdchk(`DSP_ADDR_FLAGS, 32'h0);
    wr(`DSP_ADDR_CMP_B, 32'h5);
    wr(`DSP_ADDR_CTRL, ctrl(4'ha, 3'h1, 2'h2, 2'h3));
    repeat (20) @(posedge pclk);
    wr(`DSP_ADDR_FLAGS, 32'hf);
    repeat (20) @(posedge pclk);
    wr(`DSP_ADDR_CTRL, ctrl(4'ha, 3'h0, 2'h2, 2'h3));
    rdchk(`DSP_ADDR_FLAGS, 32'hb);
    $display("Test flags done");

    // Compare A or capture as TOP, toggle and frequency correct modes
    wr(`DSP_ADDR_CMP_A, 32'h3);
    wr(`DSP_ADDR_CMP_B, 32'h2);
    // Load active compares at TOP so compare A as TOP never sits below the count
    wr(`DSP_ADDR_CTRL, ctrl(4'ha, 3'h1, 2'h2, 2'h3));
    repeat (20) @(posedge pclk);
    for (int k = 0; k < 3; k++) begin
      wr(`DSP_ADDR_CTRL, ctrl(fm[k], 3'h1, fa[k], fb[k]));
      repeat (30) @(posedge pclk);
      wr(`DSP_ADDR_FLAGS, 32'hf);
      measure(60);
      check(ha, fea[k]);
      if (k == 2) begin
        check(hb, 40);
      end
      check({wave_oe_a, wave_oe_b}, {1'b1, k == 2});
      wr(`DSP_ADDR_CTRL, ctrl(fm[k], 3'h0, fa[k], fb[k]));
      rdchk(`DSP_ADDR_FLAGS, ff[k]);
    end
    wr(`DSP_ADDR_PIN_DIR, 32'h0);
    repeat (2) @(posedge pclk);
    check({wave_oe_a, wave_oe_b}, 2'h0);
    $display("Test top sources done");
    test_done();
  end
endmodule : dsp_pwm_timer_test
